// File: hdl/dcef_top.sv
// dma channel event flags with avalon-mm register slave
// Operation
// - set destination done when pointer equals size
// - set half flag when pointer equals half
// - block flag on largest size or match
// - cell flag after each cell size bytes
// - matching abort request aborts, sets abort flag
// - address error flag on bad source/destination
`timescale 1ns/1ps
module dcef_top
    import dcef_pkg::*;
(
    input wire logic mclk, // system clock, 100 MHz
    input wire logic srst, // synchronous reset, active high
    input wire logic [DCEF_ADDR_W-1:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [3:0] avs_byteenable, // write byte lanes
    input wire logic [31:0] avs_writedata, // write data
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall the master
    input wire logic byte_moved, // engine moved one byte this cycle
    input wire logic [DCEF_SIZE_W-1:0] destination_pointer, // engine destination pointer
    input wire logic pattern_match, // pulse: pattern match seen
    input wire logic irq_seen, // pulse: an interrupt request occurred
    input wire logic [DCEF_IRQ_W-1:0] irq_number, // number of that request
    input wire logic src_addr_bad, // pulse: source address invalid
    input wire logic dst_addr_bad, // pulse: destination address invalid
    output logic chan_enable, // channel may run
    output logic chan_abort, // pulse: transfer aborted
    output logic [DCEF_FLAG_W-1:0] event_flags, // sticky flags
    output logic irq // level interrupt
);
    logic ack_q;
    logic req;
    logic wr_now;
    logic rd_now;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic chan_en_q;
    logic [DCEF_FLAG_W-1:0] flags_q;
    logic [DCEF_FLAG_W-1:0] flags_d;
    logic [DCEF_FLAG_W-1:0] mask_q;
    logic [DCEF_FLAG_W-1:0] set_vec;
    logic [DCEF_FLAG_W-1:0] clr_vec;
    logic [DCEF_SIZE_W-1:0] src_size_q;
    logic [DCEF_SIZE_W-1:0] dst_size_q;
    logic [DCEF_SIZE_W-1:0] cell_size_q;
    logic [DCEF_IRQ_W-1:0] abort_sel_q;
    logic [DCEF_SIZE_W-1:0] block_size;
    logic [DCEF_SIZE_W-1:0] half_size;
    logic [DCEF_SIZE_W-1:0] cell_count;
    logic [DCEF_SIZE_W-1:0] block_count;
    logic cell_done;
    logic block_done;
    logic done_match;
    logic half_match;
    logic done_match_q;
    logic half_match_q;
    logic abort_hit;
    logic chan_abort_q;
    logic moving;
    logic restart;

    // bus handshake: one wait cycle, answer on the second
    assign req = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_q;
    assign wr_now = avs_write && ack_q;
    assign rd_now = avs_read && ack_q;

    always_ff @(posedge mclk) begin
        if (srst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
        end
    end

    // read mux, captured in the wait cycle so data is stable at the ack edge
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (avs_address)
            DCEF_OFF_CTRL: rdata_d[DCEF_BIT_CHAN_EN] = chan_en_q;
            DCEF_OFF_FLAGS: rdata_d[DCEF_FLAG_W-1:0] = flags_q;
            DCEF_OFF_MASK: rdata_d[DCEF_FLAG_W-1:0] = mask_q;
            DCEF_OFF_SRC_SIZE: rdata_d[DCEF_SIZE_W-1:0] = src_size_q;
            DCEF_OFF_DST_SIZE: rdata_d[DCEF_SIZE_W-1:0] = dst_size_q;
            DCEF_OFF_CELL_SIZE: rdata_d[DCEF_SIZE_W-1:0] = cell_size_q;
            DCEF_OFF_ABORT_SEL: rdata_d[DCEF_IRQ_W-1:0] = abort_sel_q;
            DCEF_OFF_PROGRESS: rdata_d = {block_count, cell_count};
            default: rdata_d = 32'h0000_0000; // unmapped reads as zero
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            rdata_q <= rdata_d;
        end
    end
    assign avs_readdata = rdata_q;

    // size and select registers, low two byte lanes only
    always_ff @(posedge mclk) begin
        if (srst) begin
            src_size_q <= DCEF_RST_SIZE;
            dst_size_q <= DCEF_RST_SIZE;
            cell_size_q <= DCEF_RST_SIZE;
            abort_sel_q <= DCEF_RST_ABORT_SEL;
        end else if (wr_now) begin
            for (int i = 0; i < 2; i++) begin
                if (avs_byteenable[i]) begin
                    if (avs_address == DCEF_OFF_SRC_SIZE) begin
                        src_size_q[i*8 +: 8] <= avs_writedata[i*8 +: 8];
                    end
                    if (avs_address == DCEF_OFF_DST_SIZE) begin
                        dst_size_q[i*8 +: 8] <= avs_writedata[i*8 +: 8];
                    end
                    if (avs_address == DCEF_OFF_CELL_SIZE) begin
                        cell_size_q[i*8 +: 8] <= avs_writedata[i*8 +: 8];
                    end
                end
            end
            if (avs_address == DCEF_OFF_ABORT_SEL && avs_byteenable[0]) begin
                abort_sel_q <= avs_writedata[DCEF_IRQ_W-1:0];
            end
        end
    end

    // interrupt mask register
    always_ff @(posedge mclk) begin
        if (srst) begin
            mask_q <= DCEF_RST_MASK;
        end else if (wr_now && avs_address == DCEF_OFF_MASK && avs_byteenable[0]) begin
            mask_q <= avs_writedata[DCEF_FLAG_W-1:0];
        end
    end

    // abort detection: selected request number while running
    assign abort_hit = chan_en_q && irq_seen && (irq_number == abort_sel_q);

    // channel enable: software sets, an abort drops it; abort beats a write
    always_ff @(posedge mclk) begin
        if (srst) begin
            chan_en_q <= DCEF_RST_CHAN_EN;
        end else if (abort_hit) begin
            chan_en_q <= 1'b0;
        end else if (wr_now && avs_address == DCEF_OFF_CTRL && avs_byteenable[0]) begin
            chan_en_q <= avs_writedata[DCEF_BIT_CHAN_EN];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            chan_abort_q <= 1'b0;
        end else begin
            chan_abort_q <= abort_hit;
        end
    end
    assign chan_enable = chan_en_q;
    assign chan_abort = chan_abort_q;

    // byte counting only while enabled; restart on abort, disable or pattern match
    assign moving = chan_en_q && byte_moved;
    assign restart = abort_hit || !chan_en_q || (chan_en_q && pattern_match);
    assign block_size = (src_size_q > dst_size_q) ? src_size_q : dst_size_q;

    dcef_byte_counter u_cell (
        .mclk(mclk),
        .srst(srst),
        .clear(restart || block_done),
        .step(moving),
        .limit(cell_size_q),
        .done(cell_done),
        .count(cell_count)
    );

    dcef_byte_counter u_block (
        .mclk(mclk),
        .srst(srst),
        .clear(restart),
        .step(moving),
        .limit(block_size),
        .done(block_done),
        .count(block_count)
    );

    // pointer compares; only the rising match counts, so a parked pointer fires once
    assign half_size = {1'b0, dst_size_q[DCEF_SIZE_W-1:1]};
    assign done_match = chan_en_q && (dst_size_q != DCEF_RST_SIZE) && (destination_pointer == dst_size_q);
    assign half_match = chan_en_q && (half_size != DCEF_RST_SIZE) && (destination_pointer == half_size);

    always_ff @(posedge mclk) begin
        if (srst) begin
            done_match_q <= 1'b0;
            half_match_q <= 1'b0;
        end else begin
            done_match_q <= done_match;
            half_match_q <= half_match;
        end
    end

    // event sources for each flag bit
    always_comb begin
        set_vec = DCEF_RST_FLAGS;
        set_vec[DCEF_BIT_DST_DONE] = done_match && !done_match_q;
        set_vec[DCEF_BIT_DST_HALF] = half_match && !half_match_q;
        set_vec[DCEF_BIT_BLOCK] = block_done || (chan_en_q && pattern_match);
        set_vec[DCEF_BIT_CELL] = cell_done;
        set_vec[DCEF_BIT_ABORT] = abort_hit;
        set_vec[DCEF_BIT_ADDR_ERR] = chan_en_q && (src_addr_bad || dst_addr_bad);
    end

    // clears: only the flags the read reported, or write-one-to-clear;
    // an event landing between capture and ack would otherwise be lost unseen
    always_comb begin
        clr_vec = DCEF_RST_FLAGS;
        if (rd_now && avs_address == DCEF_OFF_FLAGS) begin
            clr_vec = rdata_q[DCEF_FLAG_W-1:0];
        end else if (wr_now && avs_address == DCEF_OFF_FLAGS && avs_byteenable[0]) begin
            clr_vec = avs_writedata[DCEF_FLAG_W-1:0];
        end
    end

    // set applied after clear so a same-cycle event is never lost
    assign flags_d = (flags_q & ~clr_vec) | set_vec;

    always_ff @(posedge mclk) begin
        if (srst) begin
            flags_q <= DCEF_RST_FLAGS;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign event_flags = flags_q;
    assign irq = |(flags_q & mask_q);
endmodule

// File: hdl/dcef_pkg.sv
// shared constants for the dma channel event flag block
package dcef_pkg;
    // register word offsets (byte addresses)
    localparam logic [7:0] DCEF_OFF_CTRL = 8'h00;
    localparam logic [7:0] DCEF_OFF_FLAGS = 8'h04;
    localparam logic [7:0] DCEF_OFF_MASK = 8'h08;
    localparam logic [7:0] DCEF_OFF_SRC_SIZE = 8'h0C;
    localparam logic [7:0] DCEF_OFF_DST_SIZE = 8'h10;
    localparam logic [7:0] DCEF_OFF_CELL_SIZE = 8'h14;
    localparam logic [7:0] DCEF_OFF_ABORT_SEL = 8'h18;
    localparam logic [7:0] DCEF_OFF_PROGRESS = 8'h1C;
    // widths
    localparam int DCEF_ADDR_W = 8;
    localparam int DCEF_SIZE_W = 16;
    localparam int DCEF_IRQ_W = 8;
    localparam int DCEF_FLAG_W = 6;
    // flag bit positions
    localparam int DCEF_BIT_ADDR_ERR = 0;
    localparam int DCEF_BIT_ABORT = 1;
    localparam int DCEF_BIT_CELL = 2;
    localparam int DCEF_BIT_BLOCK = 3;
    localparam int DCEF_BIT_DST_HALF = 4;
    localparam int DCEF_BIT_DST_DONE = 5;
    // control register field
    localparam int DCEF_BIT_CHAN_EN = 0;
    // reset values
    localparam logic [DCEF_FLAG_W-1:0] DCEF_RST_FLAGS = 6'h00;
    localparam logic [DCEF_FLAG_W-1:0] DCEF_RST_MASK = 6'h00;
    localparam logic [DCEF_SIZE_W-1:0] DCEF_RST_SIZE = 16'h0000;
    localparam logic [DCEF_IRQ_W-1:0] DCEF_RST_ABORT_SEL = 8'hFF;
    localparam logic DCEF_RST_CHAN_EN = 1'b0;
endpackage

// File: hdl/dcef_byte_counter.sv
// byte counter that pulses when a programmed limit is reached
`timescale 1ns/1ps
module dcef_byte_counter
    import dcef_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic srst, // synchronous reset, active high
    input wire logic clear, // restart the count
    input wire logic step, // one byte moved
    input wire logic [DCEF_SIZE_W-1:0] limit, // bytes per unit, zero disables
    output logic done, // pulse: last byte of the unit moved
    output logic [DCEF_SIZE_W-1:0] count // bytes moved in current unit
);
    logic [DCEF_SIZE_W-1:0] count_q;
    logic [DCEF_SIZE_W-1:0] count_d;
    logic hit;

    // limit reached on this step; zero limit never fires
    assign hit = step && (limit != DCEF_RST_SIZE) && ((count_q + 16'h0001) == limit);
    assign done = hit;
    assign count = count_q;

    // next count: wrap on hit so back to back units keep counting
    always_comb begin
        count_d = count_q;
        if (clear || hit) begin
            count_d = DCEF_RST_SIZE;
        end else if (step) begin
            count_d = count_q + 16'h0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            count_q <= DCEF_RST_SIZE;
        end else begin
            count_q <= count_d;
        end
    end
endmodule

// File: bench/dcef_checker.sv
// port-level assertions for the event flag block
`timescale 1ns/1ps
module dcef_checker
    import dcef_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic srst, // synchronous reset
    input wire logic [DCEF_ADDR_W-1:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic avs_waitrequest, // slave stall
    input wire logic byte_moved, // byte moved
    input wire logic pattern_match, // match pulse
    input wire logic irq_seen, // request pulse
    input wire logic src_addr_bad, // bad source
    input wire logic dst_addr_bad, // bad destination
    input wire logic chan_enable, // channel on
    input wire logic chan_abort, // abort pulse
    input wire logic [DCEF_FLAG_W-1:0] event_flags, // sticky flags
    input wire logic irq // level interrupt
);
    logic [DCEF_FLAG_W-1:0] flags_q;
    logic flag_acc_q;
    // last cycle's flags and whether it finished a flag register access
    always_ff @(posedge mclk) begin
        flags_q <= event_flags;
        flag_acc_q <= (avs_address == DCEF_OFF_FLAGS) && (avs_read || avs_write) && !avs_waitrequest;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    chk_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus stalled longer than one cycle");
    chk_abort_cause: assert property ($rose(event_flags[DCEF_BIT_ABORT]) |->
        $past(irq_seen) && $past(chan_enable) && chan_abort && !chan_enable) else $error("abort flag without cause");
    chk_abort_pulse: assert property (chan_abort |=> !chan_abort) else $error("abort wider than one cycle");
    chk_addr_err: assert property (chan_enable && (src_addr_bad || dst_addr_bad) |=>
        event_flags[DCEF_BIT_ADDR_ERR]) else $error("address error flag missing");
    chk_flag_sticky: assert property (|(flags_q & ~event_flags) |-> flag_acc_q)
        else $error("flag dropped without software clear");
    chk_quiet_off: assert property (!chan_enable |=> (event_flags & ~flags_q) == 6'h00)
        else $error("flag set while channel off");
    chk_cell_cause: assert property ($rose(event_flags[DCEF_BIT_CELL]) |-> $past(byte_moved))
        else $error("cell flag without byte moved");
    chk_block_cause: assert property ($rose(event_flags[DCEF_BIT_BLOCK]) |->
        $past(byte_moved) || $past(pattern_match)) else $error("block flag without cause");
    chk_match_block: assert property (chan_enable && pattern_match |=> event_flags[DCEF_BIT_BLOCK])
        else $error("pattern match did not set block flag");
    chk_irq_src: assert property (irq |-> event_flags != 6'h00) else $error("interrupt without flag");
endmodule
bind dcef_top dcef_checker dcef_checker_inst (.mclk(mclk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .byte_moved(byte_moved),
    .pattern_match(pattern_match), .irq_seen(irq_seen), .src_addr_bad(src_addr_bad),
    .dst_addr_bad(dst_addr_bad), .chan_enable(chan_enable), .chan_abort(chan_abort),
    .event_flags(event_flags), .irq(irq));

// File: bench/dcef_engine_model.sv
// engine stand-in: moves one byte per cycle while told to run
`timescale 1ns/1ps
module dcef_engine_model
    import dcef_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic srst, // synchronous reset
    input wire logic run, // bench asks for moves
    input wire logic chan_enable, // channel may run
    output logic byte_moved, // one byte this cycle
    output logic [DCEF_SIZE_W-1:0] destination_pointer // bytes written so far
);
    // a stopped channel moves nothing, as the real engine
    assign byte_moved = run & chan_enable;
    // pointer restarts whenever the channel is off
    always_ff @(posedge mclk) begin
        if (srst || !chan_enable) begin
            destination_pointer <= 16'h0000;
        end else if (byte_moved) begin
            destination_pointer <= destination_pointer + 16'h0001;
        end
    end
endmodule

// File: bench/dcef_top_tb_top.sv
// self-checking bench for the event flag block
`timescale 1ns/1ps
module dcef_top_tb_top;
    import dcef_pkg::*;
    logic mclk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, run = 1'b0;
    logic [7:0] avs_address = 8'h00, irq_number = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [3:0] evt = 4'h0;
    logic [15:0] destination_pointer;
    logic [5:0] event_flags;
    logic avs_waitrequest, byte_moved, chan_enable, chan_abort, irq;
    wire logic pattern_match, irq_seen, src_addr_bad, dst_addr_bad;
    int bad_count = 0, n_checks = 0, cyc = 0;
    assign {pattern_match, irq_seen, src_addr_bad, dst_addr_bad} = evt;
    dcef_top dcef_top_inst (.mclk(mclk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(4'hF), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .byte_moved(byte_moved), .destination_pointer(destination_pointer),
        .pattern_match(pattern_match), .irq_seen(irq_seen), .irq_number(irq_number), .src_addr_bad(src_addr_bad),
        .dst_addr_bad(dst_addr_bad), .chan_enable(chan_enable), .chan_abort(chan_abort),
        .event_flags(event_flags), .irq(irq));
    dcef_engine_model dcef_engine_model_inst (.mclk(mclk), .srst(srst), .run(run), .chan_enable(chan_enable),
        .byte_moved(byte_moved), .destination_pointer(destination_pointer));
    initial forever #5 mclk = ~mclk;
    task automatic summarize;
        if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
        end
    endtask
    // one bus cycle; request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(nm, rd, exp);
    endtask
    // one-cycle event pulse on the selected inputs
    task automatic ev(input logic [3:0] e);
        @(posedge mclk);
        evt <= e;
        @(posedge mclk);
        evt <= 4'h0;
    endtask
    task automatic moves(input int n);
        @(posedge mclk);
        run <= 1'b1;
        repeat (n) @(posedge mclk);
        run <= 1'b0;
    endtask
    task automatic t_reset;
        rd_chk("ctrl", DCEF_OFF_CTRL, 32'h0);
        rd_chk("mask", DCEF_OFF_MASK, 32'h0);
        rd_chk("abort select", DCEF_OFF_ABORT_SEL, 32'hFF);
        rd_chk("dst size", DCEF_OFF_DST_SIZE, 32'h0);
        bus(1'b1, 8'h40, 32'hFFFFFFFF);
        rd_chk("unmapped", 8'h40, 32'h0);
    endtask
    task automatic t_addr_err;
        bus(1'b1, DCEF_OFF_CTRL, 32'h1);
        ev(4'h2);
        rd_chk("src error", DCEF_OFF_FLAGS, 32'h01);
        rd_chk("read clear", DCEF_OFF_FLAGS, 32'h0);
        ev(4'h1);
        rd_chk("dst error", DCEF_OFF_FLAGS, 32'h01);
    endtask
    task automatic t_abort;
        bus(1'b1, DCEF_OFF_ABORT_SEL, 32'h21);
        irq_number <= 8'h20;
        ev(4'h4);
        rd_chk("other request", DCEF_OFF_FLAGS, 32'h0);
        irq_number <= 8'h21;
        ev(4'h4);
        @(negedge mclk);
        check("abort pulse", chan_abort, 1'b1);
        check("enable after abort", chan_enable, 1'b0);
        rd_chk("abort flag", DCEF_OFF_FLAGS, 32'h02);
    endtask
    // block is the larger size, so nothing at the source size of 4
    task automatic t_count;
        bus(1'b1, DCEF_OFF_DST_SIZE, 32'h8);
        bus(1'b1, DCEF_OFF_SRC_SIZE, 32'h4);
        bus(1'b1, DCEF_OFF_CELL_SIZE, 32'h2);
        bus(1'b1, DCEF_OFF_CTRL, 32'h1);
        rd_chk("src size", DCEF_OFF_SRC_SIZE, 32'h4);
        moves(2);
        rd_chk("cell", DCEF_OFF_FLAGS, 32'h04);
        rd_chk("progress", DCEF_OFF_PROGRESS, 32'h0002_0000);
        moves(2);
        rd_chk("half", DCEF_OFF_FLAGS, 32'h14);
        moves(4);
        rd_chk("done block", DCEF_OFF_FLAGS, 32'h2C);
    endtask
    task automatic t_irq;
        bus(1'b1, DCEF_OFF_MASK, 32'h08);
        ev(4'h8);
        repeat (4) @(negedge mclk);
        check("irq", irq, 1'b1);
        check("match flag", event_flags, 6'h08);
        bus(1'b1, DCEF_OFF_FLAGS, 32'h08);
        @(negedge mclk);
        check("flags cleared", event_flags, 6'h00);
        check("irq low", irq, 1'b0);
    endtask
    // source error lands on the very edge that write-clears it
    task automatic t_set_wins;
        fork
            bus(1'b1, DCEF_OFF_FLAGS, 32'h01);
            begin
                repeat (2) @(posedge mclk);
                evt <= 4'h2;
                @(posedge mclk);
                evt <= 4'h0;
            end
        join
        rd_chk("set beats clear", DCEF_OFF_FLAGS, 32'h01);
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        t_reset();
        t_addr_err();
        t_abort();
        t_count();
        t_irq();
        t_set_wins();
        summarize();
    end
    // hang guard, well beyond the hundred-odd cycles the run needs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            summarize();
        end
    end
endmodule
